// file: rtl/capture_compare_pkg.sv
// Constants, field layouts and state types of the dual capture/compare array.
// Function
// - Two units, sixteen channels each, thirty-two total.
// - Two 16-bit reloadable timers per unit.
// - Timer clock: prescaled clock or general-purpose overflow.
// - First timer may count external input edges.
// - Channel picks timer and capture or compare.
// - One pin per channel, input or output.
// - Capture loads timer value, raises channel interrupt.
// - Capture on rising, falling or both edges.
// - Compare channels matched once against each new timer value.
// - Mode 0: interrupt per match, pin untouched.
// - Mode 1: pin toggles on every match.
// - Mode 2: one interrupt per timer period.
// - Mode 3: pin high on match, low on overflow.
// - Double mode: two registers toggle one pin.
// - Select codes divide clock by 8 to 1024.
// - Overflow reloads; zero reload gives full period.
package capture_compare_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int UNITS = 2;
    localparam int CH_PER_UNIT = 16;
    localparam int CHANNELS = 32;
    localparam int TMR_W = 16;
    localparam int PRE_W = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ==========================================================
    // Register map: word addresses; bit 6 picks the unit
    // ==========================================================
    localparam logic [5:0] OFS_CH_VAL = 6'h00;
    localparam logic [5:0] OFS_CH_CTRL = 6'h10;
    localparam logic [5:0] OFS_TMR0_CNT = 6'h20;
    localparam logic [5:0] OFS_TMR0_REL = 6'h21;
    localparam logic [5:0] OFS_TMR0_CTRL = 6'h22;
    localparam logic [5:0] OFS_TMR1_CNT = 6'h23;
    localparam logic [5:0] OFS_TMR1_REL = 6'h24;
    localparam logic [5:0] OFS_TMR1_CTRL = 6'h25;
    localparam logic [5:0] OFS_STATUS = 6'h26;
    localparam logic [5:0] OFS_MASK = 6'h27;
    localparam int UNIT_BIT = 6;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CH_MODE_LSB = 0;
    localparam int CH_TSEL_BIT = 4;
    localparam int TC_SEL_LSB = 0;
    localparam int TC_SRC_LSB = 3;
    localparam int TC_RUN_BIT = 5;

    // ==========================================================
    // Channel modes and timer sources
    // ==========================================================
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_RISE = 4'h1;
    localparam logic [3:0] MODE_CAP_FALL = 4'h2;
    localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
    localparam logic [3:0] MODE_CMP0 = 4'h4;
    localparam logic [3:0] MODE_CMP1 = 4'h5;
    localparam logic [3:0] MODE_CMP2 = 4'h6;
    localparam logic [3:0] MODE_CMP3 = 4'h7;
    localparam logic [3:0] MODE_DOUBLE = 4'h8;

    localparam logic [1:0] SRC_PRESCALE = 2'h0;
    localparam logic [1:0] SRC_GP_OVF = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;

    localparam logic [3:0] PRE_BASE_SHIFT = 4'h3;
    localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;
    localparam logic [TMR_W-1:0] RESET_VALUE = 16'h0000;

    // ==========================================================
    // State types
    // ==========================================================
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic [TMR_W-1:0] rel;
        logic run;
        logic [1:0] src;
        logic [2:0] sel;
    } timer_s;

    typedef struct packed {
        logic [TMR_W-1:0] val;
        logic tsel;
        logic [3:0] mode;
        logic done;
    } chan_s;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        timer_s [UNITS-1:0][1:0] tmr;
        logic [UNITS-1:0][1:0] upd;
        chan_s [CHANNELS-1:0] ch;
        logic [CHANNELS-1:0] pinS1;
        logic [CHANNELS-1:0] pinS2;
        logic [CHANNELS-1:0] pinS3;
        logic [UNITS-1:0] cntS1;
        logic [UNITS-1:0] cntS2;
        logic [UNITS-1:0] cntS3;
        logic [UNITS-1:0][CH_PER_UNIT-1:0] stat;
        logic [UNITS-1:0][CH_PER_UNIT-1:0] mask;
        logic [CHANNELS-1:0] pinOut;
        logic [CHANNELS-1:0] pinDriveN;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } state_s;

endpackage

// file: rtl/dual_capture_compare_array.sv
// Dual capture/compare array with four time-base timers and a plain register port.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dual_capture_compare_array (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [capture_compare_pkg::ADDR_W-1:0] regAddr,
    input wire logic [capture_compare_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [capture_compare_pkg::DATA_W-1:0] regRdata,
    input wire logic gpOverflow,
    input wire logic [capture_compare_pkg::UNITS-1:0] countPin,
    input wire logic [capture_compare_pkg::CHANNELS-1:0] pinIn,
    output logic [capture_compare_pkg::CHANNELS-1:0] pinOut,
    output logic [capture_compare_pkg::CHANNELS-1:0] pinDriveN,
    output logic irq
);

    capture_compare_pkg::state_s s;
    capture_compare_pkg::state_s next_s;

    // ==========================================================
    // Outputs
    // ==========================================================
    assign regRdata = s.rdata;
    assign pinOut = s.pinOut;
    assign pinDriveN = s.pinDriveN;
    assign irq = s.irq;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic [capture_compare_pkg::UNITS-1:0][1:0] ovf;
        logic [capture_compare_pkg::CHANNELS-1:0] rise;
        logic [capture_compare_pkg::CHANNELS-1:0] fall;
        logic [capture_compare_pkg::UNITS-1:0] cntEdge;
        logic [capture_compare_pkg::CHANNELS-1:0] tog;
        logic [capture_compare_pkg::CHANNELS-1:0] evt;
        logic [capture_compare_pkg::PRE_W-1:0] pmask;
        logic tick;
        logic match;
        logic unitSel;
        logic [5:0] ofs;
        logic [3:0] chIdx;
        logic [3:0] mode;
        logic [capture_compare_pkg::TMR_W-1:0] tval;
        int u;
        int lo;
        int mate;
        ovf = '0;
        tog = '0;
        evt = '0;
        pmask = '0;
        tick = 1'b0;
        match = 1'b0;
        tval = '0;
        mode = capture_compare_pkg::MODE_OFF;
        u = 0;
        lo = 0;
        mate = 0;
        unitSel = regAddr[capture_compare_pkg::UNIT_BIT];
        ofs = regAddr[5:0];
        chIdx = regAddr[3:0];
        next_s = s;

        // Input synchronisers; edges are taken only from the second and third stages.
        next_s.pinS1 = pinIn;
        next_s.pinS2 = s.pinS1;
        next_s.pinS3 = s.pinS2;
        next_s.cntS1 = countPin;
        next_s.cntS2 = s.cntS1;
        next_s.cntS3 = s.cntS2;
        rise = s.pinS2 & ~s.pinS3;
        fall = ~s.pinS2 & s.pinS3;
        cntEdge = s.cntS2 & ~s.cntS3;

        // ======================================================
        // Register writes
        // ======================================================
        if (regWrite && !regAddr[7]) begin
            if (ofs < capture_compare_pkg::OFS_CH_CTRL) begin
                next_s.ch[{unitSel, chIdx}].val = regWdata;
            end else if (ofs < capture_compare_pkg::OFS_TMR0_CNT) begin
                next_s.ch[{unitSel, chIdx}].mode = regWdata[capture_compare_pkg::CH_MODE_LSB +: 4];
                next_s.ch[{unitSel, chIdx}].tsel = regWdata[capture_compare_pkg::CH_TSEL_BIT];
                next_s.ch[{unitSel, chIdx}].done = 1'b0;
            end else begin
                case (ofs)
                    capture_compare_pkg::OFS_TMR0_CNT: next_s.tmr[unitSel][0].cnt = regWdata;
                    capture_compare_pkg::OFS_TMR0_REL: next_s.tmr[unitSel][0].rel = regWdata;
                    capture_compare_pkg::OFS_TMR0_CTRL: begin
                        next_s.tmr[unitSel][0].sel = regWdata[capture_compare_pkg::TC_SEL_LSB +: 3];
                        next_s.tmr[unitSel][0].src = regWdata[capture_compare_pkg::TC_SRC_LSB +: 2];
                        next_s.tmr[unitSel][0].run = regWdata[capture_compare_pkg::TC_RUN_BIT];
                    end
                    capture_compare_pkg::OFS_TMR1_CNT: next_s.tmr[unitSel][1].cnt = regWdata;
                    capture_compare_pkg::OFS_TMR1_REL: next_s.tmr[unitSel][1].rel = regWdata;
                    capture_compare_pkg::OFS_TMR1_CTRL: begin
                        next_s.tmr[unitSel][1].sel = regWdata[capture_compare_pkg::TC_SEL_LSB +: 3];
                        next_s.tmr[unitSel][1].src = regWdata[capture_compare_pkg::TC_SRC_LSB +: 2];
                        next_s.tmr[unitSel][1].run = regWdata[capture_compare_pkg::TC_RUN_BIT];
                    end
                    capture_compare_pkg::OFS_STATUS: next_s.stat[unitSel] = s.stat[unitSel] & ~regWdata;
                    capture_compare_pkg::OFS_MASK: next_s.mask[unitSel] = regWdata;
                    default: begin
                    end
                endcase
            end
        end

        // ======================================================
        // Time-base timers
        // ======================================================
        next_s.pre = s.pre + 10'h001;
        for (int t = 0; t < 2 * capture_compare_pkg::UNITS; t++) begin
            u = t / 2;
            pmask = ~(10'h3FF << ({1'b0, s.tmr[u][t % 2].sel} + capture_compare_pkg::PRE_BASE_SHIFT));
            case (s.tmr[u][t % 2].src)
                capture_compare_pkg::SRC_PRESCALE: tick = (s.pre & pmask) == pmask;
                capture_compare_pkg::SRC_GP_OVF: tick = gpOverflow;
                capture_compare_pkg::SRC_EXT: tick = (t % 2 == 0) && cntEdge[u];
                default: tick = 1'b0;
            endcase
            tick = tick && s.tmr[u][t % 2].run;
            next_s.upd[u][t % 2] = tick;
            if (tick) begin
                if (s.tmr[u][t % 2].cnt == capture_compare_pkg::TMR_MAX) begin
                    next_s.tmr[u][t % 2].cnt = s.tmr[u][t % 2].rel;
                    ovf[u][t % 2] = 1'b1;
                end else begin
                    next_s.tmr[u][t % 2].cnt = s.tmr[u][t % 2].cnt + 16'h0001;
                end
            end
        end

        // ======================================================
        // Channels
        // ======================================================
        for (int c = 0; c < capture_compare_pkg::CHANNELS; c++) begin
            u = c / capture_compare_pkg::CH_PER_UNIT;
            lo = c % capture_compare_pkg::CH_PER_UNIT;
            // The lower channel paired with this one; it stays in range for the lower half as well.
            mate = (lo >= capture_compare_pkg::CH_PER_UNIT / 2) ? c - capture_compare_pkg::CH_PER_UNIT / 2 : c;
            mode = s.ch[c].mode;
            tval = s.tmr[u][s.ch[c].tsel].cnt;
            // A match is taken once, in the cycle after the timer takes a new value.
            match = s.upd[u][s.ch[c].tsel] && (s.ch[c].val == tval);
            if (ovf[u][s.ch[c].tsel]) begin
                next_s.ch[c].done = 1'b0;
                if (mode == capture_compare_pkg::MODE_CMP3) begin
                    next_s.pinOut[c] = 1'b0;
                end
            end
            case (mode)
                capture_compare_pkg::MODE_CAP_RISE,
                capture_compare_pkg::MODE_CAP_FALL,
                capture_compare_pkg::MODE_CAP_BOTH: begin
                    if ((rise[c] && mode != capture_compare_pkg::MODE_CAP_FALL) ||
                        (fall[c] && mode != capture_compare_pkg::MODE_CAP_RISE)) begin
                        next_s.ch[c].val = tval;
                        evt[c] = 1'b1;
                    end
                end
                capture_compare_pkg::MODE_CMP0: begin
                    evt[c] = match;
                end
                capture_compare_pkg::MODE_CMP1: begin
                    evt[c] = match;
                    tog[c] = match;
                end
                capture_compare_pkg::MODE_CMP2: begin
                    if (match && !s.ch[c].done) begin
                        evt[c] = 1'b1;
                        next_s.ch[c].done = 1'b1;
                    end
                end
                capture_compare_pkg::MODE_CMP3: begin
                    if (match && !s.ch[c].done) begin
                        evt[c] = 1'b1;
                        next_s.ch[c].done = 1'b1;
                        next_s.pinOut[c] = 1'b1;
                    end
                end
                capture_compare_pkg::MODE_DOUBLE: begin
                    if (lo < capture_compare_pkg::CH_PER_UNIT / 2) begin
                        evt[c] = match;
                        tog[c] = tog[c] ^ match;
                    end
                end
                default: begin
                end
            endcase
            // The upper partner of a double-mode channel toggles the lower channel's pin.
            if (lo >= capture_compare_pkg::CH_PER_UNIT / 2 &&
                s.ch[mate].mode == capture_compare_pkg::MODE_DOUBLE) begin
                evt[c] = evt[c] | match;
                tog[mate] = tog[mate] ^ match;
            end
            // Only pin-driving compare modes own the pin as an output.
            next_s.pinDriveN[c] = !(mode == capture_compare_pkg::MODE_CMP1 ||
                                    mode == capture_compare_pkg::MODE_CMP3 ||
                                    (mode == capture_compare_pkg::MODE_DOUBLE &&
                                     lo < capture_compare_pkg::CH_PER_UNIT / 2));
        end
        next_s.pinOut = next_s.pinOut ^ tog;

        // ======================================================
        // Interrupt status: a new event wins over a clear
        // ======================================================
        next_s.stat = next_s.stat | evt;
        next_s.irq = |(next_s.stat & next_s.mask);

        // ======================================================
        // Register reads
        // ======================================================
        next_s.rdata = '0;
        if (regRead && !regAddr[7]) begin
            if (ofs < capture_compare_pkg::OFS_CH_CTRL) begin
                next_s.rdata = s.ch[{unitSel, chIdx}].val;
            end else if (ofs < capture_compare_pkg::OFS_TMR0_CNT) begin
                next_s.rdata = {11'h000, s.ch[{unitSel, chIdx}].tsel, s.ch[{unitSel, chIdx}].mode};
            end else begin
                case (ofs)
                    capture_compare_pkg::OFS_TMR0_CNT: next_s.rdata = s.tmr[unitSel][0].cnt;
                    capture_compare_pkg::OFS_TMR0_REL: next_s.rdata = s.tmr[unitSel][0].rel;
                    capture_compare_pkg::OFS_TMR0_CTRL: next_s.rdata = {10'h000, s.tmr[unitSel][0].run,
                                                                        s.tmr[unitSel][0].src, s.tmr[unitSel][0].sel};
                    capture_compare_pkg::OFS_TMR1_CNT: next_s.rdata = s.tmr[unitSel][1].cnt;
                    capture_compare_pkg::OFS_TMR1_REL: next_s.rdata = s.tmr[unitSel][1].rel;
                    capture_compare_pkg::OFS_TMR1_CTRL: next_s.rdata = {10'h000, s.tmr[unitSel][1].run,
                                                                        s.tmr[unitSel][1].src, s.tmr[unitSel][1].sel};
                    capture_compare_pkg::OFS_STATUS: next_s.rdata = s.stat[unitSel];
                    capture_compare_pkg::OFS_MASK: next_s.rdata = s.mask[unitSel];
                    default: next_s.rdata = '0;
                endcase
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.pinDriveN <= '1;
        end else begin
            s <= next_s;
        end
    end

endmodule

// file: dv/dual_capture_compare_array_properties.sv
// Port-level properties of the dual capture/compare array.
`timescale 1ns/1ps
module dual_capture_compare_array_properties (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic gpOverflow,
    input wire logic [1:0] countPin,
    input wire logic [31:0] pinIn,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinDriveN,
    input wire logic irq
);
    // ==========
    // Helper state
    // ==========
    logic maskSeen;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Remembers whether software has ever enabled an interrupt source.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            maskSeen <= 1'b0;
        end else if (regWrite && !regAddr[7] && regAddr[5:0] == 6'h27 && regWdata != 16'h0000) begin
            maskSeen <= 1'b1;
        end
    end

    // ==========
    // Properties
    // ==========
    a_read_idle_zero: assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data not zero outside the read slot");
    a_write_no_data: assert property (regWrite && !regRead |=> regRdata == 16'h0000)
        else $error("write produced read data");
    a_unmapped_zero: assert property ($past(regRead) && ($past(regAddr[7]) || $past(regAddr[5:0]) > 6'h27)
        |-> regRdata == 16'h0000) else $error("unmapped read returned data");
    a_reset_outputs: assert property ($fell(sys_rst) |-> !irq && pinDriveN == '1 && regRdata == 16'h0000)
        else $error("outputs not at reset level after reset");
    a_irq_needs_mask: assert property (irq |-> maskSeen)
        else $error("interrupt raised with no source enabled");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(regWrite) && $past(regAddr[5:1]) == 5'h13)
        else $error("interrupt dropped without a status or mask write");
    a_drive_by_ctrl: assert property ($changed(pinDriveN) |->
        ($past(regWrite) && $past(regAddr[5:4]) == 2'b01) || ($past(regWrite, 2) && $past(regAddr[5:4], 2) == 2'b01))
        else $error("pin drive enable changed without a channel control write");
    a_undriven_still: assert property (((pinOut ^ $past(pinOut)) & pinDriveN & $past(pinDriveN)) == '0)
        else $error("undriven pin output changed");
endmodule

// file: dv/pin_partner.sv
// External pin and count-input model for the capture/compare array.
`timescale 1ns/1ps
module pin_partner (
    input wire logic ref_clk,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinDriveN,
    output logic [31:0] pinIn,
    output logic [1:0] countPin
);
    logic [31:0] extLevel = 32'h0000_0000;

    // A pin the device drives reads back its own level; otherwise the outside world sets it.
    assign pinIn = (pinOut & ~pinDriveN) | (extLevel & pinDriveN);

    initial countPin = 2'b00;

    task automatic setPins(input logic [31:0] sel, input logic lvl);
        @(posedge ref_clk);
        extLevel <= lvl ? (extLevel | sel) : (extLevel & ~sel);
    endtask

    // Pulses are held long enough to pass a three-stage synchroniser.
    task automatic pulseCount(input logic [1:0] sel, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            countPin <= sel;
            repeat (4) @(posedge ref_clk);
            countPin <= 2'b00;
            repeat (3) @(posedge ref_clk);
        end
    endtask
endmodule

// file: dv/tb_dual_capture_compare_array.sv
// Self-checking testbench of the dual capture/compare array.
`timescale 1ns/1ps
module tb_dual_capture_compare_array;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic gpOverflow = 1'b0;
    logic [15:0] regRdata;
    logic [1:0] countPin;
    logic [31:0] pinIn;
    logic [31:0] pinOut;
    logic [31:0] pinDriveN;
    logic irq;
    logic [64:0] obs;
    logic [15:0] got;
    logic [7:0] modes [6] = '{8'h04, 8'h05, 8'h07, 8'h06, 8'h14, 8'h08};
    int badCount = 0;
    int testsRun = 0;

    assign obs = {irq, pinDriveN, pinOut};

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    dual_capture_compare_array dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .gpOverflow(gpOverflow), .countPin(countPin),
        .pinIn(pinIn), .pinOut(pinOut), .pinDriveN(pinDriveN), .irq(irq));

    pin_partner partner (.ref_clk(ref_clk), .pinOut(pinOut), .pinDriveN(pinDriveN), .pinIn(pinIn),
        .countPin(countPin));

    // ==========
    // Access and compare tasks
    // ==========
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
        @(posedge ref_clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
        rd(a, got);
        testsRun++;
        if (got !== e) begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic chkRange(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        testsRun++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, g, lo, hi);
        end
    endtask

    // Bit 64 is the interrupt, 32 up are drive enables, the rest pin levels.
    task automatic chkBit(input int i, input logic e);
        @(negedge ref_clk);
        testsRun++;
        if (obs[i] !== e) begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, obs[i], e);
        end
        @(posedge ref_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            gpOverflow <= 1'b1;
            @(posedge ref_clk);
            gpOverflow <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========
    // Tests
    // ==========
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        wr(8'h80, 16'hFFFF);
        wr(8'h28, 16'hFFFF);
        rdChk(8'h80, 16'h0000);
        rdChk(8'h28, 16'h0000);
        rdChk(8'h26, 16'h0000);
        chkBit(64, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(i[7:0], (i == 5) ? 16'h0013 : 16'h0012);
            wr(8'h10 + i[7:0], {8'h00, modes[i]});
        end
        wr(8'h0D, 16'h0015);
        wr(8'h1D, 16'h0008);
        wr(8'h27, 16'h000F);
        wr(8'h21, 16'h0010);
        wr(8'h20, 16'hFFFE);
        wr(8'h22, 16'h0028);
        tick(2);
        rdChk(8'h20, 16'h0010);
        tick(2);
        rdChk(8'h26, 16'h000F);
        chkBit(64, 1'b1);
        chkBit(1, 1'b1);
        chkBit(33, 1'b0);
        chkBit(2, 1'b1);
        wr(8'h26, 16'h000F);
        chkBit(64, 1'b0);
        wr(8'h20, 16'h0011);
        tick(1);
        rdChk(8'h26, 16'h0003);
        chkBit(1, 1'b0);
        wr(8'h20, 16'hFFFF);
        tick(1);
        chkBit(2, 1'b0);
        tick(3);
        chkBit(5, 1'b1);
        tick(2);
        chkBit(5, 1'b0);
        // Channel 4 follows the second timer: only its match may show in the status.
        wr(8'h26, 16'hFFFF);
        wr(8'h23, 16'h0011);
        wr(8'h25, 16'h0028);
        tick(1);
        rdChk(8'h26, 16'h0010);
        wr(8'h60, 16'h0100);
        wr(8'h62, 16'h0028);
        for (int i = 0; i < 3; i++) begin
            wr(8'h50 + i[7:0], 16'h0001 + i[15:0]);
        end
        partner.setPins(32'h0007_0000, 1'b1);
        repeat (5) @(posedge ref_clk);
        rdChk(8'h66, 16'h0005);
        tick(2);
        partner.setPins(32'h0007_0000, 1'b0);
        repeat (5) @(posedge ref_clk);
        rdChk(8'h66, 16'h0007);
        rdChk(8'h40, 16'h0100);
        rdChk(8'h41, 16'h0102);
        rdChk(8'h42, 16'h0102);
        wr(8'h22, 16'h0030);
        wr(8'h20, 16'h0000);
        partner.pulseCount(2'b01, 3);
        rdChk(8'h20, 16'h0003);
        for (int s = 0; s < 8; s++) begin
            wr(8'h25, 16'h0000);
            wr(8'h23, 16'h0000);
            wr(8'h25, 16'h0020 | s[15:0]);
            repeat (4 << (s + 3)) @(posedge ref_clk);
            wr(8'h25, 16'h0000);
            rd(8'h23, got);
            chkRange(got, 16'h0004, 16'h0005);
        end
        conclude();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        badCount++;
        $display("Watchdog expired before the tests finished");
        conclude();
    end
endmodule

bind dual_capture_compare_array dual_capture_compare_array_properties props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .gpOverflow(gpOverflow), .countPin(countPin), .pinIn(pinIn), .pinOut(pinOut), .pinDriveN(pinDriveN), .irq(irq));
